//--- rtl/svd_pkg.sv
// package: register map, field layout, reset values and states of the video output registers
package svd_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_FORMAT = 12'h008;
  localparam logic [11:0] OFS_TOP = 12'h00c;
  localparam logic [11:0] OFS_BOTTOM = 12'h010;
  localparam logic [11:0] OFS_STRIDE = 12'h014;
  // ---------------------------------------------------------------
  // field positions in the format register
  // ---------------------------------------------------------------
  localparam int FMT_SAME_FIELDS = 20;
  localparam int FMT_HDROP_LO = 14;
  localparam int FMT_VDROP_LO = 8;
  localparam int FMT_SINGLE = 6;
  localparam int FMT_OUTSEL_LO = 3;
  localparam int FMT_DIFFUSE = 2;
  localparam int FMT_PACK = 1;
  localparam int FMT_LOW_FIRST = 0;
  // ---------------------------------------------------------------
  // field positions in the stride / status / grab register
  // ---------------------------------------------------------------
  localparam int STR_LINE_INC_LO = 18;
  localparam int STR_OVERRUN = 8;
  localparam int STR_GRAB_MODE = 1;
  localparam int STR_GRAB_GO = 0;
  // ---------------------------------------------------------------
  // reset values, decimation load phases and word size
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_OUTSEL = 2'h2;
  localparam logic [29:0] RST_DEST = 30'h03ff_ffff;
  localparam logic [13:0] RST_LINE_INC = 14'h3fff;
  localparam logic [5:0] PHASE_TOP = 6'h00;
  localparam logic [5:0] PHASE_BOTTOM = 6'h20;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // ---------------------------------------------------------------
  // output pixel formats
  // ---------------------------------------------------------------
  localparam logic [1:0] OUT_YUV422 = 2'h0;
  localparam logic [1:0] OUT_RGB888 = 2'h1;
  localparam logic [1:0] OUT_RGB565 = 2'h2;
  localparam logic [1:0] OUT_RGB555 = 2'h3;
  // frame grab sequencer
  typedef enum logic [1:0] {GRAB_IDLE, GRAB_WAIT, GRAB_FIRST, GRAB_SECOND} svd_grab_t;
endpackage : svd_pkg

//--- rtl/svd_decim.sv
// module: drops a programmed count of items out of every group of 2**W
`timescale 1ns/10ps
module svd_decim #(
  parameter int W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_phase,
  input wire logic step,
  input wire logic [W-1:0] drop_count,
  output logic keep
);
  logic [W-1:0] phase;
  logic [W:0] sum;

  // an item is dropped whenever the phase accumulator wraps, spreading drops evenly
  assign sum = {1'b0, phase} + {1'b0, drop_count};
  assign keep = ~sum[W];

  // phase reload wins over a step in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= '0;
    else if (load)
      phase <= load_phase;
    else if (step)
      phase <= sum[W-1:0];
  end
endmodule : svd_decim

//--- rtl/svd_regs.sv
// module: APB register bank and output path of the video scaler / display stage
`timescale 1ns/10ps
module svd_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic field_start,
  input wire logic field_is_top,
  input wire logic line_end,
  input wire logic pix_valid,
  input wire logic [23:0] pix_rgb,
  input wire logic [15:0] pix_yuv,
  input wire logic pixel_fifo_over,
  output logic xfer_on,
  output logic out_valid,
  output logic [31:0] out_data,
  output logic [31:0] out_addr
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic same_fields_flag;
  logic [5:0] horiz_drop_count;
  logic [5:0] vert_drop_count;
  logic single_field_select;
  logic [1:0] output_format_sel;
  logic diffusion_on;
  logic packed_truecolor;
  logic low_byte_first;
  logic [29:0] upper_field_dest;
  logic [29:0] lower_field_dest;
  logic [13:0] line_increment;
  logic pixel_fifo_overrun;
  logic grab_mode;
  logic grab_go;
  svd_pkg::svd_grab_t grab_state;
  logic wr;
  logic setup;
  logic grab_done;
  logic [31:0] rd_word;
  logic hit;

  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign pready = 1'b1;

  // address decode for the error answer; the read mux decodes the same offsets in its own case
  function automatic logic svd_mapped(input logic [11:0] a);
    svd_mapped = (a == svd_pkg::OFS_FORMAT) || (a == svd_pkg::OFS_TOP) ||
      (a == svd_pkg::OFS_BOTTOM) || (a == svd_pkg::OFS_STRIDE);
  endfunction : svd_mapped

  assign hit = svd_mapped(paddr);
  assign pslverr = psel & penable & ~hit;

  // format register write; reserved bits are simply not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      same_fields_flag <= 1'b0;
      horiz_drop_count <= 6'h00;
      vert_drop_count <= 6'h00;
      single_field_select <= 1'b0;
      output_format_sel <= svd_pkg::RST_OUTSEL;
      diffusion_on <= 1'b0;
      packed_truecolor <= 1'b0;
      low_byte_first <= 1'b1;
    end
    else if (wr && paddr == svd_pkg::OFS_FORMAT)
    begin
      same_fields_flag <= pwdata[svd_pkg::FMT_SAME_FIELDS];
      horiz_drop_count <= pwdata[svd_pkg::FMT_HDROP_LO +: 6];
      vert_drop_count <= pwdata[svd_pkg::FMT_VDROP_LO +: 6];
      single_field_select <= pwdata[svd_pkg::FMT_SINGLE];
      output_format_sel <= pwdata[svd_pkg::FMT_OUTSEL_LO +: 2];
      diffusion_on <= pwdata[svd_pkg::FMT_DIFFUSE];
      packed_truecolor <= pwdata[svd_pkg::FMT_PACK];
      low_byte_first <= pwdata[svd_pkg::FMT_LOW_FIRST];
    end
  end

  // destination bases keep only the word address bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_field_dest <= svd_pkg::RST_DEST;
      lower_field_dest <= svd_pkg::RST_DEST;
      line_increment <= svd_pkg::RST_LINE_INC;
      grab_mode <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == svd_pkg::OFS_TOP)
        upper_field_dest <= pwdata[31:2];
      if (paddr == svd_pkg::OFS_BOTTOM)
        lower_field_dest <= pwdata[31:2];
      if (paddr == svd_pkg::OFS_STRIDE)
      begin
        line_increment <= pwdata[31:svd_pkg::STR_LINE_INC_LO];
        grab_mode <= pwdata[svd_pkg::STR_GRAB_MODE];
      end
    end
  end

  // sticky overrun; a new overflow beats the clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pixel_fifo_overrun <= 1'b0;
    else if (pixel_fifo_over)
      pixel_fifo_overrun <= 1'b1;
    else if (wr && paddr == svd_pkg::OFS_STRIDE && pwdata[svd_pkg::STR_OVERRUN])
      pixel_fifo_overrun <= 1'b0;
  end

  // grab command: completion clear beats a coincident host write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      grab_go <= 1'b0;
    else if (grab_done)
      grab_go <= 1'b0;
    else if (wr && paddr == svd_pkg::OFS_STRIDE && pwdata[svd_pkg::STR_GRAB_MODE])
      grab_go <= pwdata[svd_pkg::STR_GRAB_GO];
  end

  // read word assembled from state, every other bit zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      svd_pkg::OFS_FORMAT:
      begin
        rd_word[svd_pkg::FMT_SAME_FIELDS] = same_fields_flag;
        rd_word[svd_pkg::FMT_HDROP_LO +: 6] = horiz_drop_count;
        rd_word[svd_pkg::FMT_VDROP_LO +: 6] = vert_drop_count;
        rd_word[svd_pkg::FMT_SINGLE] = single_field_select;
        rd_word[svd_pkg::FMT_OUTSEL_LO +: 2] = output_format_sel;
        rd_word[svd_pkg::FMT_DIFFUSE] = diffusion_on;
        rd_word[svd_pkg::FMT_PACK] = packed_truecolor;
        rd_word[svd_pkg::FMT_LOW_FIRST] = low_byte_first;
      end
      svd_pkg::OFS_TOP: rd_word = {upper_field_dest, 2'h0};
      svd_pkg::OFS_BOTTOM: rd_word = {lower_field_dest, 2'h0};
      svd_pkg::OFS_STRIDE:
      begin
        rd_word[31:svd_pkg::STR_LINE_INC_LO] = line_increment;
        rd_word[svd_pkg::STR_OVERRUN] = pixel_fifo_overrun;
        rd_word[svd_pkg::STR_GRAB_MODE] = grab_mode;
        rd_word[svd_pkg::STR_GRAB_GO] = grab_go;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= rd_word;
  end

  // ---------------------------------------------------------------
  // frame grab sequencer
  // ---------------------------------------------------------------
  assign grab_done = (grab_state == svd_pkg::GRAB_SECOND) && field_start;

  // two whole fields are captured, each bounded by field_start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      grab_state <= svd_pkg::GRAB_IDLE;
    else
      case (grab_state)
        svd_pkg::GRAB_IDLE:
          if (grab_mode && grab_go)
            grab_state <= svd_pkg::GRAB_WAIT;
        svd_pkg::GRAB_WAIT:
          if (!grab_mode)
            grab_state <= svd_pkg::GRAB_IDLE;
          else if (field_start)
            grab_state <= svd_pkg::GRAB_FIRST;
        svd_pkg::GRAB_FIRST:
          if (field_start)
            grab_state <= svd_pkg::GRAB_SECOND;
        svd_pkg::GRAB_SECOND:
          if (field_start)
            grab_state <= svd_pkg::GRAB_IDLE;
        default: grab_state <= svd_pkg::GRAB_IDLE;
      endcase
  end

  // continuous video unless grab mode; in grab mode only the two fields pass
  assign xfer_on = !grab_mode ||
    grab_state == svd_pkg::GRAB_FIRST || grab_state == svd_pkg::GRAB_SECOND;

  // ---------------------------------------------------------------
  // decimation
  // ---------------------------------------------------------------
  logic h_keep;
  logic v_keep;
  logic [5:0] v_phase;
  logic take;

  // interlaced fields are offset half a group so the fields interleave
  assign v_phase = (same_fields_flag || field_is_top) ?
    svd_pkg::PHASE_TOP : svd_pkg::PHASE_BOTTOM;

  svd_decim #(.W(6)) u_hdec (
    .pclk(pclk),
    .presetn(presetn),
    .load(line_end | field_start),
    .load_phase(svd_pkg::PHASE_TOP),
    .step(pix_valid),
    .drop_count(horiz_drop_count),
    .keep(h_keep)
  );

  svd_decim #(.W(6)) u_vdec (
    .pclk(pclk),
    .presetn(presetn),
    .load(field_start),
    .load_phase(v_phase),
    .step(line_end),
    .drop_count(vert_drop_count),
    .keep(v_keep)
  );

  assign take = pix_valid & h_keep & v_keep & xfer_on;

  // ---------------------------------------------------------------
  // pixel formatting
  // ---------------------------------------------------------------
  logic [7:0] r_d;
  logic [7:0] g_d;
  logic [7:0] b_d;
  logic [2:0] err_r;
  logic [2:0] err_g;
  logic [2:0] err_b;
  logic [15:0] pix16;
  logic [2:0] g_mask;

  // adds the carried remainder and saturates at full scale
  function automatic logic [7:0] svd_dither(input logic [7:0] v, input logic [2:0] e);
    logic [8:0] s;
    s = {1'b0, v} + {6'h00, e};
    svd_dither = s[8] ? 8'hff : s[7:0];
  endfunction : svd_dither

  assign g_mask = (output_format_sel == svd_pkg::OUT_RGB565) ? 3'h3 : 3'h7;
  assign r_d = svd_dither(pix_rgb[23:16], err_r);
  assign g_d = svd_dither(pix_rgb[15:8], err_g);
  assign b_d = svd_dither(pix_rgb[7:0], err_b);

  // remainders carry along a line only; zero error means plain truncation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_r <= 3'h0;
      err_g <= 3'h0;
      err_b <= 3'h0;
    end
    else if (line_end || !diffusion_on || !output_format_sel[1])
    begin
      err_r <= 3'h0;
      err_g <= 3'h0;
      err_b <= 3'h0;
    end
    else if (take)
    begin
      err_r <= r_d[2:0];
      err_g <= g_d[2:0] & g_mask;
      err_b <= b_d[2:0];
    end
  end

  // 16-bit pixel for YUV and the two short RGB formats
  always_comb
  begin
    case (output_format_sel)
      svd_pkg::OUT_RGB565: pix16 = {r_d[7:3], g_d[7:2], b_d[7:3]};
      svd_pkg::OUT_RGB555: pix16 = {1'b0, r_d[7:3], g_d[7:3], b_d[7:3]};
      default: pix16 = pix_yuv;
    endcase
  end

  // ---------------------------------------------------------------
  // word assembly
  // ---------------------------------------------------------------
  logic [1:0] phase;
  logic [23:0] rest;
  logic emit;
  logic [31:0] word;
  logic is888;

  assign is888 = output_format_sel == svd_pkg::OUT_RGB888;

  // packed 888 spans four phases; 16-bit pixels pair two per word
  always_comb
  begin
    emit = 1'b0;
    word = 32'h0000_0000;
    if (take)
    begin
      if (is888 && !packed_truecolor)
      begin
        emit = 1'b1;
        word = {8'h00, pix_rgb};
      end
      else if (is888)
      begin
        emit = phase != 2'h0;
        case (phase)
          2'h1: word = {pix_rgb[7:0], rest};
          2'h2: word = {pix_rgb[15:0], rest[15:0]};
          2'h3: word = {pix_rgb, rest[7:0]};
          default: word = 32'h0000_0000;
        endcase
      end
      else
      begin
        emit = phase[0];
        word = {pix16, rest[15:0]};
      end
    end
  end

  // residue of the bytes not yet sent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 2'h0;
      rest <= 24'h00_0000;
    end
    else if (line_end || field_start)
      phase <= 2'h0;
    else if (take)
    begin
      phase <= (is888 && !packed_truecolor) ? 2'h0 :
        (is888 ? phase + 2'h1 : {1'b0, ~phase[0]});
      case (phase)
        2'h0: rest <= is888 ? pix_rgb : {8'h00, pix16};
        2'h1: rest <= {8'h00, pix_rgb[23:8]};
        2'h2: rest <= {16'h0000, pix_rgb[23:16]};
        default: rest <= 24'h00_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output word and destination address
  // ---------------------------------------------------------------
  logic [31:0] wptr;
  logic [31:0] field_base;
  logic [31:0] stride_bytes;

  // single field display writes every field at the top base
  assign field_base = (field_is_top || single_field_select) ?
    {upper_field_dest, 2'h0} : {lower_field_dest, 2'h0};
  assign stride_bytes = {16'h0000, line_increment, 2'h0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wptr <= 32'h0000_0000;
    else if (field_start)
      wptr <= field_base;
    else if (line_end && v_keep)
      wptr <= wptr + (emit ? svd_pkg::WORD_BYTES : 32'h0000_0000) + stride_bytes;
    else if (emit)
      wptr <= wptr + svd_pkg::WORD_BYTES;
  end

  // big endian reverses the byte lanes of each word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data <= 32'h0000_0000;
      out_addr <= 32'h0000_0000;
    end
    else
    begin
      out_valid <= emit;
      if (emit)
      begin
        out_data <= low_byte_first ? word :
          {word[7:0], word[15:8], word[23:16], word[31:24]};
        out_addr <= wptr;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_OVR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    pixel_fifo_over |=> pixel_fifo_overrun)
    else $error("overrun flag not set by overflow");
  AST_OVR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == svd_pkg::OFS_STRIDE && pwdata[8] && !pixel_fifo_over
    |=> !pixel_fifo_overrun)
    else $error("overrun flag not cleared by write of one");
  AST_GRAB_END: assert property (@(posedge pclk) disable iff (!presetn)
    grab_state == svd_pkg::GRAB_SECOND && field_start |=> !grab_go && !xfer_on || !grab_mode)
    else $error("grab did not complete after second field");
  AST_GRAB_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    grab_state == svd_pkg::GRAB_WAIT && field_start && grab_mode |=> xfer_on)
    else $error("grab transfer did not start at field start");
  AST_CONT: assert property (@(posedge pclk) disable iff (!presetn)
    !grab_mode |-> xfer_on)
    else $error("continuous mode blocked transfer");
  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == svd_pkg::OFS_FORMAT |=> prdata[31:21] == 11'h000 && !prdata[7] && !prdata[5])
    else $error("reserved format bits read nonzero");
  AST_NODROP: assert property (@(posedge pclk) disable iff (!presetn)
    horiz_drop_count == 6'h00 |-> h_keep)
    else $error("pixel dropped with decimation off");
  AST_PACK: assert property (@(posedge pclk) disable iff (!presetn)
    take && is888 && packed_truecolor && phase == 2'h0 |=> !out_valid ##1 1'b1)
    else $error("packed mode emitted a word on first pixel");
  AST_STRIDE: assert property (@(posedge pclk) disable iff (!presetn)
    line_end && v_keep && !emit && !field_start |=> wptr == $past(wptr) + $past(stride_bytes))
    else $error("next line address wrong");
  AST_ENDIAN: assert property (@(posedge pclk) disable iff (!presetn)
    emit && !low_byte_first |=> out_data[7:0] == $past(word[31:24]))
    else $error("big endian byte order wrong");
endmodule : svd_regs

//--- tb/svd_src_model.sv
// video source model: field starts, lines and pixels into the scaler
`timescale 1ns/10ps
module svd_src_model (
  input wire logic pclk,
  output logic field_start,
  output logic field_is_top,
  output logic line_end,
  output logic pix_valid,
  output logic [23:0] pix_rgb,
  output logic [15:0] pix_yuv
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial
  begin
    field_start = 1'b0;
    field_is_top = 1'b1;
    line_end = 1'b0;
    pix_valid = 1'b0;
    pix_rgb = 24'h000000;
    pix_yuv = 16'h0000;
  end

  // ---------------------------------------------------------------
  // stream tasks
  // ---------------------------------------------------------------
  // one field start pulse, field kind held as a level afterwards
  task automatic vsync(input logic top);
    @(posedge pclk);
    field_start <= 1'b1;
    field_is_top <= top;
    @(posedge pclk);
    field_start <= 1'b0;
  endtask : vsync

  // n pixels back to back, then a line end on a cycle of its own
  task automatic line(input int n, input logic [23:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      pix_valid <= 1'b1;
      pix_rgb <= base + 24'h010101 * i[23:0];
      pix_yuv <= base[15:0] + 16'h0101 * i[15:0];
    end
    @(posedge pclk);
    pix_valid <= 1'b0;
    pix_rgb <= ~pix_rgb; // unqualified data never repeats the last pixel
    pix_yuv <= ~pix_yuv;
    line_end <= 1'b1;
    @(posedge pclk);
    line_end <= 1'b0;
  endtask : line
endmodule : svd_src_model

//--- tb/testbench.sv
// self-checking bench for the video scaler register bank
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pixel_fifo_over;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, out_data, out_addr, rdv;
  logic field_start, field_is_top, line_end, pix_valid, xfer_on, out_valid, err;
  logic [23:0] pix_rgb;
  logic [15:0] pix_yuv;
  logic [31:0] qa[$];
  logic [31:0] qd[$];
  logic [31:0] fexp [4] = '{32'h3557_3456, 32'h0012_3456, 32'h11aa_11aa, 32'h08ca_08ca};
  int errors, total_checks;

  // 25 MHz bus clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  svd_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .field_start(field_start), .field_is_top(field_is_top),
    .line_end(line_end), .pix_valid(pix_valid), .pix_rgb(pix_rgb), .pix_yuv(pix_yuv),
    .pixel_fifo_over(pixel_fifo_over), .xfer_on(xfer_on), .out_valid(out_valid),
    .out_data(out_data), .out_addr(out_addr));
  svd_src_model src (.pclk(pclk), .field_start(field_start), .field_is_top(field_is_top),
    .line_end(line_end), .pix_valid(pix_valid), .pix_rgb(pix_rgb), .pix_yuv(pix_yuv));

  // output words collected as they leave, one cycle pulses
  always @(posedge pclk)
  begin
    if (out_valid === 1'b1)
    begin
      qa.push_back(out_addr);
      qd.push_back(out_data);
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; ovf raises an overflow at the very commit edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic ovf);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    pixel_fifo_over <= ovf;
    n = 0;
    do
    begin
      @(posedge pclk);
      pixel_fifo_over <= 1'b0;
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      chk(32'h0, 32'h1); // slave never answered
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdv, exp);
  endtask : rd

  // one field of nl lines with n pixels each, collecting fresh
  task automatic fld(input logic top, input int nl, input int n);
    qa.delete();
    qd.delete();
    src.vsync(top);
    repeat (nl) src.line(n, 24'h123456);
    repeat (4) @(posedge pclk);
  endtask : fld

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // watchdog, far beyond the six hundred or so cycles the tests need
  initial
  begin
    #800000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pixel_fifo_over = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h008, 32'h0000_0011);
    rd(12'h00c, 32'h0fff_fffc);
    rd(12'h010, 32'h0fff_fffc);
    rd(12'h014, 32'hfffc_0000);
    chk({31'h0, xfer_on}, 32'h1);
    wr(12'h008, 32'hffff_ffff);
    rd(12'h008, 32'h001f_ff5f);
    wr(12'h00c, 32'h0000_0103);
    rd(12'h00c, 32'h0000_0100);
    wr(12'h010, 32'h0000_0202);
    rd(12'h010, 32'h0000_0200);
    wr(12'h014, 32'hffff_fefc);
    rd(12'h014, 32'hfffc_0000);
    apb(1'b0, 12'h020, 32'h0, 1'b0);
    chk({rdv[30:0], err}, 32'h1);
    // every output format, little endian, first word at the top base
    for (int f = 0; f < 4; f++)
    begin
      wr(12'h008, 32'h1 | (32'(f) << 3));
      fld(1'b1, 1, 2);
      chk(qa[0], 32'h0000_0100);
      chk(qd[0], fexp[f]);
    end
    // second line starts one stride past the end of the first
    wr(12'h014, 32'h0040_0000);
    wr(12'h008, 32'h0000_0009);
    fld(1'b1, 2, 2);
    chk(qa[1], 32'h0000_0104);
    chk(qa[2], 32'h0000_0148);
    wr(12'h008, 32'h0000_0008);
    fld(1'b1, 1, 1);
    chk(qd[0], 32'h5634_1200);
    wr(12'h008, 32'h0000_000b);
    fld(1'b1, 1, 4);
    chk(32'(qd.size()), 32'h3);
    chk(qd[0], 32'h5712_3456);
    chk(qd[1], 32'h3658_1335);
    chk(qd[2], 32'h1537_5914);
    wr(12'h008, 32'h0000_0009);
    fld(1'b0, 1, 2);
    chk(qa[0], 32'h0000_0200);
    // adjacent lines in single field mode: stride zero, next line follows directly
    wr(12'h014, 32'h0000_0000);
    wr(12'h008, 32'h0000_0049);
    fld(1'b0, 2, 2);
    chk(qa[0], 32'h0000_0100);
    chk(qa[2], 32'h0000_0108);
    wr(12'h008, 32'h0008_0009);
    fld(1'b1, 1, 64);
    chk(32'(qd.size()), 32'd32);
    wr(12'h008, 32'h0000_2009);
    fld(1'b1, 64, 1);
    chk(32'(qd.size()), 32'd32);
    // same fields: bottom starts on the top pattern, keep drop keep
    wr(12'h008, 32'h0010_2009);
    fld(1'b0, 3, 1);
    chk(32'(qd.size()), 32'd2);
    // interlaced bottom is offset half a group: drop keep drop
    wr(12'h008, 32'h0000_2009);
    fld(1'b0, 3, 1);
    chk(32'(qd.size()), 32'd1);
    // 565 with diffusion: remainders of the first pixel lift the second
    wr(12'h008, 32'h0000_0015);
    fld(1'b1, 1, 2);
    chk(qd[0], 32'h11ab_11aa);
    // frame grab: refused outside grab mode, two fields, then stop
    wr(12'h008, 32'h0000_0009);
    wr(12'h014, 32'h0000_0001);
    rd(12'h014, 32'h0000_0000);
    wr(12'h014, 32'h0000_0002);
    @(negedge pclk); // grab mode lands at the commit edge; look once it has settled
    chk({31'h0, xfer_on}, 32'h0);
    wr(12'h014, 32'h0000_0003);
    rd(12'h014, 32'h0000_0003);
    fld(1'b1, 1, 2);
    chk(32'(qd.size()), 32'h2);
    fld(1'b0, 1, 2);
    chk(32'(qd.size()), 32'h2);
    fork
      apb(1'b1, 12'h014, 32'h0000_0003, 1'b0);
      begin
        @(posedge pclk);
        src.vsync(1'b1);
      end
    join
    rd(12'h014, 32'h0000_0002);
    chk({31'h0, xfer_on}, 32'h0);
    fld(1'b1, 1, 2);
    chk(32'(qd.size()), 32'h0);
    // overflow flag: sticky, cleared by one, a coincident overflow wins
    @(posedge pclk);
    pixel_fifo_over <= 1'b1;
    @(posedge pclk);
    pixel_fifo_over <= 1'b0;
    rd(12'h014, 32'h0000_0102);
    rd(12'h014, 32'h0000_0102);
    wr(12'h014, 32'h0000_0102);
    rd(12'h014, 32'h0000_0002);
    apb(1'b1, 12'h014, 32'h0000_0102, 1'b1);
    rd(12'h014, 32'h0000_0102);
    give_verdict();
  end
endmodule : testbench
